// >>> verilog/pps_pkg.sv
/*
 * Constants and carrier types for one transceiver port's status register.
 * Assumes a management engine that turns serial frames into single-cycle
 * read and write strobes on the reference clock.
 */
// Functional notes
// - Bits 14..11 capability, set by straps.
// - Bit 6 preamble suppression always one.
// - Bit 5 shows negotiation complete.
// - Negotiation disabled forces bit 5 zero.
// - Bit 4 latches remote fault until read.
// - Bit 3 follows strapped negotiation ability.
// - Bit 2 latches link failure until read.
// - Bit 1 latches jabber, zero at 100M.
// - Bit 0 extended capability always one.
// - Bit 15 T4 capability always zero.
// - Control bit 12 enables negotiation, defaults one.
package pps_pkg;

    localparam int unsigned ADDR_W       = 5;
    localparam int unsigned DATA_W       = 16;

    localparam logic [4:0]  ADDR_CTRL    = 5'h00;
    localparam logic [4:0]  ADDR_STATUS  = 5'h01;

    localparam int unsigned CTRL_AN_EN   = 12;

    localparam int unsigned ST_T4        = 15;
    localparam int unsigned ST_CAP_HI    = 14;
    localparam int unsigned ST_CAP_LO    = 11;
    localparam int unsigned ST_PRE_SUP   = 6;
    localparam int unsigned ST_AN_DONE   = 5;
    localparam int unsigned ST_RFAULT    = 4;
    localparam int unsigned ST_AN_ABLE   = 3;
    localparam int unsigned ST_LINK      = 2;
    localparam int unsigned ST_JABBER    = 1;
    localparam int unsigned ST_EXT_CAP   = 0;

    localparam logic        RST_AN_EN    = 1'b1;
    localparam logic        RST_LINK     = 1'b0;
    localparam logic        RST_RFAULT   = 1'b0;
    localparam logic        RST_JABBER   = 1'b0;
    localparam logic [15:0] RST_DATA     = 16'h0000;

    // Live conditions from the transceiver datapath, same clock domain.
    typedef struct packed {
        logic link_up;
        logic remote_fault;
        logic jabber;
        logic an_done;
        logic speed_100;
    } pps_ev_s;

    // Strap pins; capability order 100FD, 100HD, 10FD, 10HD.
    typedef struct packed {
        logic [3:0] cap;
        logic       an_able;
    } pps_strap_s;

endpackage : pps_pkg

// >>> verilog/pps_port_status.sv
/*
 * Status register (address 01H) and negotiation enable of control
 * register (address 00H) for one transceiver port.
 * Assumes strobes and events on I_REF_CLK; strap pins are asynchronous.
 */
`timescale 1ns/1ps
module pps_port_status
    import pps_pkg::*;
(
    input  wire logic              I_REF_CLK,
    input  wire logic              I_ARST_N,
    input  wire logic              I_RD_STB,
    input  wire logic              I_WR_STB,
    input  wire logic [ADDR_W-1:0] I_REG_ADDR,
    input  wire logic [DATA_W-1:0] I_WR_DATA,
    input  wire pps_ev_s           I_PHY_EV,
    input  wire pps_strap_s        I_STRAP,
    output logic      [DATA_W-1:0] O_RD_DATA,
    output logic                   O_RD_VALID,
    output logic                   O_AN_ENABLE
);

    ////////////////////////////////////////////////////////////////////////
    // Helpers.

    // A strobe that names the given register; shared by all decodes.
    function automatic logic pps_hit(
        input logic              stb,
        input logic [ADDR_W-1:0] addr,
        input logic [ADDR_W-1:0] target
    );
        return stb && (addr == target);
    endfunction : pps_hit

    ////////////////////////////////////////////////////////////////////////
    // Strap synchroniser. Only the second stage is read by logic, so a
    // strap that moves while the port runs cannot split one status word.
    // Reset clears both stages; straps show again two edges after release.
    pps_strap_s strap_meta_ff;
    pps_strap_s nxt_strap_meta;
    pps_strap_s strap_ff;
    pps_strap_s nxt_strap;

    always_comb begin
        nxt_strap_meta = I_STRAP;
        nxt_strap      = strap_meta_ff;
    end

    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            strap_meta_ff <= '0;
            strap_ff      <= '0;
        end else begin
            strap_meta_ff <= nxt_strap_meta;
            strap_ff      <= nxt_strap;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Strobe decode. The status address has no write decode at all, which
    // is what keeps the status word read-only.
    logic status_rd;
    logic ctrl_rd;
    logic ctrl_wr;

    always_comb begin
        status_rd = pps_hit(I_RD_STB, I_REG_ADDR, ADDR_STATUS);
        ctrl_rd   = pps_hit(I_RD_STB, I_REG_ADDR, ADDR_CTRL);
        ctrl_wr   = pps_hit(I_WR_STB, I_REG_ADDR, ADDR_CTRL);
    end

    ////////////////////////////////////////////////////////////////////////
    // Negotiation enable, control bit 12. Other control bits are not kept.
    logic an_en_ff;
    logic nxt_an_en;

    always_comb begin
        nxt_an_en = an_en_ff;
        if (ctrl_wr) begin
            nxt_an_en = I_WR_DATA[CTRL_AN_EN];
        end
    end

    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            an_en_ff <= RST_AN_EN;
        end else begin
            an_en_ff <= nxt_an_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Remote fault latch. A fault in the cycle of a read wins over the
    // clear, so an event is never lost between capture and clear.
    logic rfault_ff;
    logic nxt_rfault;

    always_comb begin
        nxt_rfault = rfault_ff;
        if (status_rd) begin
            nxt_rfault = 1'b0;
        end
        if (I_PHY_EV.remote_fault) begin
            nxt_rfault = 1'b1;
        end
    end

    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            rfault_ff <= RST_RFAULT;
        end else begin
            rfault_ff <= nxt_rfault;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Link latch, latching low. It leaves reset low, so the first read
    // after reset reports no link even when the link is already up.
    logic link_ff;
    logic nxt_link;

    always_comb begin
        nxt_link = link_ff;
        if (status_rd) begin
            nxt_link = 1'b1;
        end
        if (!I_PHY_EV.link_up) begin
            nxt_link = 1'b0;
        end
    end

    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            link_ff <= RST_LINK;
        end else begin
            link_ff <= nxt_link;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Jabber latch. Jabber is not looked for at 100 Mbps, and the reported
    // bit is masked there too, so a stale latch never shows after a speed
    // change.
    logic jabber_ff;
    logic nxt_jabber;

    always_comb begin
        nxt_jabber = jabber_ff;
        if (status_rd) begin
            nxt_jabber = 1'b0;
        end
        if (I_PHY_EV.jabber && !I_PHY_EV.speed_100) begin
            nxt_jabber = 1'b1;
        end
    end

    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            jabber_ff <= RST_JABBER;
        end else begin
            jabber_ff <= nxt_jabber;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status word as a read would capture it in this cycle. Bit 5 follows
    // the live done flag rather than a latch, so it drops at once when
    // negotiation restarts or is switched off.
    logic [DATA_W-1:0] status_word;

    always_comb begin
        status_word                        = '0;
        status_word[ST_T4]                 = 1'b0;
        status_word[ST_CAP_HI:ST_CAP_LO]   = strap_ff.cap;
        status_word[ST_PRE_SUP]            = 1'b1;
        status_word[ST_AN_DONE]            = I_PHY_EV.an_done & an_en_ff;
        status_word[ST_RFAULT]             = rfault_ff;
        status_word[ST_AN_ABLE]            = strap_ff.an_able;
        status_word[ST_LINK]               = link_ff;
        status_word[ST_JABBER]             = jabber_ff & ~I_PHY_EV.speed_100;
        status_word[ST_EXT_CAP]            = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Read port. The word is registered here and the latches are cleared
    // at the same edge, so a read reports exactly what it acknowledges.
    logic [DATA_W-1:0] rd_data_ff;
    logic [DATA_W-1:0] nxt_rd_data;
    logic              rd_valid_ff;
    logic              nxt_rd_valid;

    always_comb begin
        nxt_rd_valid = I_RD_STB;
        nxt_rd_data  = rd_data_ff;
        if (status_rd) begin
            nxt_rd_data = status_word;
        end else if (ctrl_rd) begin
            nxt_rd_data             = '0;
            nxt_rd_data[CTRL_AN_EN] = an_en_ff;
        end else if (I_RD_STB) begin
            nxt_rd_data = '0;
        end
    end

    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            rd_data_ff  <= RST_DATA;
            rd_valid_ff <= 1'b0;
        end else begin
            rd_data_ff  <= nxt_rd_data;
            rd_valid_ff <= nxt_rd_valid;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, each straight from its flip-flop, so the pins never glitch.
    assign O_RD_DATA   = rd_data_ff;
    assign O_RD_VALID  = rd_valid_ff;
    assign O_AN_ENABLE = an_en_ff;

endmodule : pps_port_status

// >>> dv/pps_sva.sv
/* Checker for the port status register; sees only its top ports. */
`timescale 1ns/1ps
module pps_sva import pps_pkg::*; (
    input wire logic I_REF_CLK,
    input wire logic I_ARST_N,
    input wire logic I_RD_STB,
    input wire logic I_WR_STB,
    input wire logic [ADDR_W-1:0] I_REG_ADDR,
    input wire logic [DATA_W-1:0] I_WR_DATA,
    input wire pps_ev_s I_PHY_EV,
    input wire pps_strap_s I_STRAP,
    input wire logic [DATA_W-1:0] O_RD_DATA,
    input wire logic O_RD_VALID,
    input wire logic O_AN_ENABLE
);
    wire rs = I_RD_STB && I_REG_ADDR == ADDR_STATUS;
    wire [15:0] d = O_RD_DATA;
    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (!I_ARST_N);
    a_zero_bits: assert property (rs |=> !d[15] && d[10:7] == 4'h0)
        else $error("fixed zero bit set");
    a_fixed_ones: assert property (rs |=> d[6] && d[0])
        else $error("fixed one bit clear");
    a_strap_bits: assert property (rs |=> {d[14:11], d[3]} == $past(I_STRAP, 3))
        else $error("strap bits differ");
    a_an_done: assert property (rs |=> d[5] == $past(I_PHY_EV.an_done && O_AN_ENABLE))
        else $error("negotiation done bit");
    a_rfault_hold: assert property (I_PHY_EV.remote_fault ##1 rs |=> d[4])
        else $error("remote fault lost");
    a_link_low: assert property (!I_PHY_EV.link_up ##1 rs |=> !d[2])
        else $error("link failure lost");
    a_jabber_mask: assert property (rs && I_PHY_EV.speed_100 |=> !d[1])
        else $error("jabber at 100M");
    a_an_write: assert property (I_WR_STB && I_REG_ADDR == ADDR_CTRL
        |=> O_AN_ENABLE == $past(I_WR_DATA[CTRL_AN_EN])) else $error("enable not written");
    a_rd_pulse: assert property (O_RD_VALID == $past(I_RD_STB))
        else $error("read valid not one cycle after strobe");
    a_rfault_clear: assert property (
        rs && !I_PHY_EV.remote_fault ##1 !I_PHY_EV.remote_fault ##1 rs |=> !d[4])
        else $error("remote fault not cleared by read");
    c_rf: cover property (rs ##1 d[4]);
    c_off: cover property (I_WR_STB ##1 !O_AN_ENABLE);
    c_jab: cover property (rs && I_PHY_EV.jabber);
    c_link: cover property (!I_PHY_EV.link_up ##1 rs);
endmodule : pps_sva
bind pps_port_status pps_sva i_pps_sva(.*);

// >>> dv/pps_mac_model.sv
/* Management master model. Assumes the reference clock only. */
`timescale 1ns/1ps
module pps_mac_model import pps_pkg::*; (
    input  wire logic i_clk,
    output logic o_rd_stb = 1'b0,
    output logic o_wr_stb = 1'b0,
    output logic [ADDR_W-1:0] o_addr = '0,
    output logic [DATA_W-1:0] o_wdata = '0
);
    task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] v);
        @(posedge i_clk);
        {o_rd_stb, o_wr_stb, o_addr, o_wdata} <= {~w, w, a, v};
        @(posedge i_clk);
        // Strobes drop; address and data show the inverse so stale values are never trusted.
        {o_rd_stb, o_wr_stb, o_addr, o_wdata} <= {2'h0, ~a, ~v};
    endtask : acc
endmodule : pps_mac_model

// >>> dv/tb_phy_port_status_register.sv
/* Bench for the port status register. Assumes pps_pkg and the MAC model. */
`timescale 1ns/1ps
module tb_phy_port_status_register import pps_pkg::*;;
    logic clk = 1'b0, rst_n = 1'b0, rd, wr, vld, an_o, an_en = 1'b1;
    logic [4:0] adr;
    logic [15:0] wd, rdat, v;
    pps_ev_s ev = '0;
    pps_strap_s st = '0;
    logic [15:0] q[$];
    int n_errors = 0, compares = 0;
    always #2.5 clk = ~clk;
    pps_mac_model i_pps_mac_model(.i_clk(clk), .o_rd_stb(rd), .o_wr_stb(wr),
        .o_addr(adr), .o_wdata(wd));
    pps_port_status i_pps_port_status(.I_REF_CLK(clk), .I_ARST_N(rst_n), .I_RD_STB(rd),
        .I_WR_STB(wr), .I_REG_ADDR(adr), .I_WR_DATA(wd), .I_PHY_EV(ev), .I_STRAP(st),
        .O_RD_DATA(rdat), .O_RD_VALID(vld), .O_AN_ENABLE(an_o));
    function automatic logic [15:0] sw(input logic [3:0] f);
        return {1'b0, st.cap, 4'h0, 1'b1, f[3] & an_en, f[2], st.an_able, f[1], f[0], 1'b1};
    endfunction : sw
    task automatic rd_q(input logic [4:0] a, input logic [15:0] e);
        q.push_back(e);
        i_pps_mac_model.acc(1'b0, a, 16'h0000);
    endtask : rd_q
    task automatic cmp_rd();
        logic [15:0] e;
        e = q.size() ? q.pop_front() : ~rdat;
        compares++;
        if (rdat !== e) begin
            n_errors++;
            $display("wrong value at %0t: read got %h want %h", $time, rdat, e);
        end
    endtask : cmp_rd
    task automatic cmp_an(input logic e);
        @(negedge clk);
        compares++;
        if (an_o !== e) begin
            n_errors++;
            $display("wrong value at %0t: enable got %b want %b", $time, an_o, e);
        end
    endtask : cmp_an
    always @(posedge clk) if (rst_n && vld !== 1'b0) cmp_rd();
    initial begin
        void'($urandom(32'h22E73E63));
        st = 5'($urandom);
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd_q(ADDR_STATUS, sw(4'h0));
        rd_q(ADDR_CTRL, 16'h1000);
        rd_q(5'h05, 16'h0000);
        cmp_an(1'b1);
        $display("reset test done");
        @(posedge clk) ev <= '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
        @(posedge clk) ev <= '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
        rd_q(ADDR_STATUS, sw(4'h5));
        rd_q(ADDR_STATUS, sw(4'h2));
        @(posedge clk) ev.link_up <= 1'b0;
        @(posedge clk) ev.link_up <= 1'b1;
        rd_q(ADDR_STATUS, sw(4'h0));
        rd_q(ADDR_STATUS, sw(4'h2));
        $display("latch test done");
        @(posedge clk) ev <= '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
        rd_q(ADDR_STATUS, sw(4'hA));
        for (int i = 0; i < 4; i++) begin
            v = i[0] ? 16'h0000 : 16'($urandom);
            i_pps_mac_model.acc(1'b1, ADDR_CTRL, v);
            an_en = v[12];
            cmp_an(an_en);
            rd_q(ADDR_CTRL, {3'h0, an_en, 12'h000});
            rd_q(ADDR_STATUS, sw(4'hA));
        end
        i_pps_mac_model.acc(1'b1, ADDR_STATUS, 16'hFFFF);
        rd_q(ADDR_STATUS, sw(4'hA));
        $display("negotiation test done");
        @(posedge clk) ev <= '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
        @(posedge clk) rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        ev <= '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
        an_en = 1'b1;
        repeat (2) @(posedge clk);
        cmp_an(1'b1);
        rd_q(ADDR_STATUS, sw(4'h0));
        $display("second reset test done");
        repeat (20) if (q.size() != 0) @(posedge clk);
        if (q.size() != 0) n_errors++;
        report_and_stop();
    end
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : report_and_stop
endmodule : tb_phy_port_status_register
